// File: logic/fts_pkg.sv
// Contract
// - Every received frame gets a 48-bit receive stamp from the wall time.
// - Receive stamp marks arrival of the first frame byte from the PHY.
// - Transmit stamp marks the instant the first frame byte is sent.
// - Residence time comes from receive and transmit stamps; queued or added.
// - Rewriter op 2 corrects residence, 3 queues transmit time, 5 writes origin.
// - Classification decides redirect or copy to CPU; all but redirected frames forward normally.
// - A nanosecond wall time runs from a one-second timer with pulse per second.
// - Wall time advances each cycle by the clock period plus 0, +1 or -1 ns.
// - Rate trim adds or removes one nanosecond at each programmed interval.
// - Absolute time setter overwrites the whole wall time under controller command.
// - Four identical capture controllers, controller n bound to sync pin n.
// - Action selects load, add delta, store current time, or clock/pulse output.
// - Sync bit makes load/store wait for a pin edge; for clock, one pulse.
// - Inverse polarity detects and generates falling edges instead of rising.
// - Each controller holds 48-bit seconds and 30-bit nanoseconds values.
// - Wave high sets clock high time, or pulse duration, in nanoseconds.
// - Wave low sets clock low time, or pulse delay after nanoseconds wrap.
// - Delta command adds the programmed nanoseconds delta to the wall time, unless a load lands in the same cycle.
// - Each executed operation interrupts; clock interrupts on going active.
// - Each controller interrupt is individually maskable.
// - Two identifier release controls: ids 32 to 63 and ids 0 to 31.
// - Each port has its own stamping unit against the shared wall time.
// - Shared 128-entry transmit stamp queue; when full drop and flag overflow.
// - Writing queue advance discards the head entry and moves the read pointer.
package fts_pkg;
	localparam int SEC_W = 48;
	localparam int NS_W = 30;
	localparam int STAMP_W = 48;
	localparam int ORIGIN_W = SEC_W + NS_W;
	localparam int ID_W = 6;
	localparam int PORT_W = 4;
	localparam int ENTRY_W = ID_W + PORT_W + STAMP_W;
	localparam int ENT_PORT_LSB = STAMP_W;
	localparam int ENT_ID_LSB = STAMP_W + PORT_W;
	localparam int NUM_CTL = 4;
	localparam int CTL_IDX_W = 2;
	localparam int Q_DEPTH = 128;
	localparam int Q_IDX_W = $clog2(Q_DEPTH);
	localparam int Q_PTR_W = Q_IDX_W + 1;
	localparam int ADDR_W = 12;
	localparam int CLK_PERIOD_NS = 20;
	localparam logic [NS_W-1:0] NS_STEP = NS_W'(CLK_PERIOD_NS);
	localparam logic [NS_W-1:0] NS_ONE = 30'h1;
	localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3B9A_CA00;
	localparam logic [2:0] OP_ONE_STEP = 3'h2;
	localparam logic [2:0] OP_TWO_STEP = 3'h3;
	localparam logic [2:0] OP_ORIGIN = 3'h5;
	localparam logic [ADDR_W-1:0] REG_WALL_SEC_LO = 12'h000;
	localparam logic [ADDR_W-1:0] REG_WALL_SEC_HI = 12'h004;
	localparam logic [ADDR_W-1:0] REG_WALL_NS = 12'h008;
	localparam logic [ADDR_W-1:0] REG_RATE_TRIM = 12'h00C;
	localparam logic [ADDR_W-1:0] REG_ID_RELEASE_LOWER = 12'h010;
	localparam logic [ADDR_W-1:0] REG_ID_RELEASE_UPPER = 12'h014;
	localparam logic [ADDR_W-1:0] REG_STAMP_QUEUE_STATUS = 12'h018;
	localparam logic [ADDR_W-1:0] REG_TX_STAMP_VALUE = 12'h01C;
	localparam logic [ADDR_W-1:0] REG_QUEUE_ADVANCE = 12'h020;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h024;
	localparam logic [ADDR_W-1:0] CTL_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] CTL_END = 12'h0C0;
	localparam logic [4:0] CTL_CTRL = 5'h00;
	localparam logic [4:0] CTL_SEC_LO = 5'h04;
	localparam logic [4:0] CTL_SEC_HI = 5'h08;
	localparam logic [4:0] CTL_NS = 5'h0C;
	localparam logic [4:0] CTL_WAVE_HIGH = 5'h10;
	localparam logic [4:0] CTL_WAVE_LOW = 5'h14;
	localparam int CTRL_ACT_LSB = 0;
	localparam int CTRL_SYNC = 2;
	localparam int CTRL_INV = 3;
	localparam int CTRL_ARM = 4;
	localparam int TRIM_MINUS = 30;
	localparam int TRIM_EN = 31;
	localparam int ST_VLD = 0;
	localparam int ST_ID_LSB = 1;
	localparam int ST_PORT_LSB = 7;
	localparam int ST_OVFL = 11;
	localparam int ST_STAMP_HI_LSB = 16;

	typedef enum logic [1:0] {
		ACT_LOAD = 2'h0,
		ACT_DELTA = 2'h1,
		ACT_STORE = 2'h2,
		ACT_CLOCK = 2'h3
	} fts_action_type;

	typedef enum logic [1:0] {
		WV_IDLE = 2'b00,
		WV_WAIT = 2'b01,
		WV_ACTIVE = 2'b11,
		WV_INACT = 2'b10
	} fts_wave_type;

	typedef struct packed {
		fts_action_type action;
		logic sync;
		logic invert;
		logic arm;
		logic [SEC_W-1:0] sec;
		logic [NS_W-1:0] ns;
		logic [NS_W-1:0] wave_high;
		logic [NS_W-1:0] wave_low;
		fts_wave_type wave;
		logic [NS_W-1:0] elapsed;
		logic pin_out;
		logic pin_oe;
	} fts_ctl_type;

	// Sum of two in-range nanosecond values, folded once; top bit is the seconds carry
	function automatic logic [NS_W:0] ns_add(input logic [NS_W-1:0] a, input logic [NS_W-1:0] b);
		logic [NS_W:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		if (sum >= {1'b0, NS_PER_SEC}) begin
			sum = sum - {1'b0, NS_PER_SEC};
			return {1'b1, sum[NS_W-1:0]};
		end
		return {1'b0, sum[NS_W-1:0]};
	endfunction : ns_add
endpackage : fts_pkg

// File: logic/fts_wall_if.sv
`timescale 1ns/1ns
interface fts_wall_if;
	logic [fts_pkg::SEC_W-1:0] sec;
	logic [fts_pkg::NS_W-1:0] ns;
	modport src (output sec, output ns);
	modport snk (input sec, input ns);
endinterface : fts_wall_if

// File: logic/fts_port_stamper.sv
`timescale 1ns/1ns
module fts_port_stamper #(
	parameter logic [fts_pkg::PORT_W-1:0] PORT_NUM = 4'h0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	fts_wall_if.snk wall,
	input wire logic rx_sof,
	input wire logic rx_redirect_req,
	input wire logic rx_copy_req,
	output logic rx_stamp_vld,
	output logic [fts_pkg::STAMP_W-1:0] rx_stamp,
	output logic rx_redirect,
	output logic rx_copy,
	output logic rx_forward,
	input wire logic tx_sof,
	input wire logic [2:0] tx_op,
	input wire logic [fts_pkg::STAMP_W-1:0] tx_rx_stamp,
	input wire logic [fts_pkg::ID_W-1:0] tx_id,
	output logic corr_vld,
	output logic [fts_pkg::NS_W-1:0] corr_residence,
	output logic origin_vld,
	output logic [fts_pkg::ORIGIN_W-1:0] origin_time,
	output logic enq_vld,
	output logic [fts_pkg::ENTRY_W-1:0] enq_entry
);
	import fts_pkg::*;

	typedef struct packed {
		logic rx_vld;
		logic [STAMP_W-1:0] rx_stamp;
		logic redirect;
		logic copy;
		logic forward;
		logic corr_vld;
		logic [NS_W-1:0] residence;
		logic origin_vld;
		logic [ORIGIN_W-1:0] origin;
		logic enq_vld;
		logic [ENTRY_W-1:0] entry;
	} fts_port_state_type;

	fts_port_state_type s;
	fts_port_state_type next_s;
	logic [STAMP_W-1:0] now;
	logic [NS_W-1:0] rx_ns;
	logic [NS_W-1:0] residence;

	// Stamp keeps the low seconds bits above the full nanoseconds field
	assign now = {wall.sec[STAMP_W-NS_W-1:0], wall.ns};
	assign rx_ns = tx_rx_stamp[NS_W-1:0];

	always_comb begin
		next_s = s;
		next_s.rx_vld = 1'b0;
		next_s.corr_vld = 1'b0;
		next_s.origin_vld = 1'b0;
		next_s.enq_vld = 1'b0;
		if (wall.ns >= rx_ns) begin
			residence = wall.ns - rx_ns;
		end else begin
			residence = wall.ns + (NS_PER_SEC - rx_ns);
		end
		if (rx_sof) begin
			next_s.rx_vld = 1'b1;
			next_s.rx_stamp = now;
			next_s.redirect = rx_redirect_req;
			next_s.copy = rx_copy_req & ~rx_redirect_req;
			next_s.forward = ~rx_redirect_req;
		end
		if (tx_sof) begin
			case (tx_op)
				OP_ONE_STEP: begin
					next_s.corr_vld = 1'b1;
					next_s.residence = residence;
				end
				OP_TWO_STEP: begin
					next_s.enq_vld = 1'b1;
					next_s.entry = {tx_id, PORT_NUM, now};
				end
				OP_ORIGIN: begin
					next_s.origin_vld = 1'b1;
					next_s.origin = {wall.sec, wall.ns};
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rx_stamp_vld = s.rx_vld;
	assign rx_stamp = s.rx_stamp;
	assign rx_redirect = s.redirect;
	assign rx_copy = s.copy;
	assign rx_forward = s.forward;
	assign corr_vld = s.corr_vld;
	assign corr_residence = s.residence;
	assign origin_vld = s.origin_vld;
	assign origin_time = s.origin;
	assign enq_vld = s.enq_vld;
	assign enq_entry = s.entry;
endmodule : fts_port_stamper

// File: logic/fts_time_stamp_top.sv
`timescale 1ns/1ns
module fts_time_stamp_top #(
	parameter int NUM_PORTS = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fts_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_PORTS-1:0] rx_sof,
	input wire logic [NUM_PORTS-1:0] rx_redirect_req,
	input wire logic [NUM_PORTS-1:0] rx_copy_req,
	output logic [NUM_PORTS-1:0] rx_stamp_vld,
	output logic [NUM_PORTS-1:0][fts_pkg::STAMP_W-1:0] rx_stamp,
	output logic [NUM_PORTS-1:0] rx_redirect,
	output logic [NUM_PORTS-1:0] rx_copy,
	output logic [NUM_PORTS-1:0] rx_forward,
	input wire logic [NUM_PORTS-1:0] tx_sof,
	input wire logic [NUM_PORTS-1:0][2:0] tx_op,
	input wire logic [NUM_PORTS-1:0][fts_pkg::STAMP_W-1:0] tx_rx_stamp,
	input wire logic [NUM_PORTS-1:0][fts_pkg::ID_W-1:0] tx_id,
	output logic [NUM_PORTS-1:0] corr_vld,
	output logic [NUM_PORTS-1:0][fts_pkg::NS_W-1:0] corr_residence,
	output logic [NUM_PORTS-1:0] origin_vld,
	output logic [NUM_PORTS-1:0][fts_pkg::ORIGIN_W-1:0] origin_time,
	input wire logic [fts_pkg::NUM_CTL-1:0] sync_pin_in,
	output logic [fts_pkg::NUM_CTL-1:0] sync_pin_out,
	output logic [fts_pkg::NUM_CTL-1:0] sync_pin_oe,
	output logic pps,
	output logic [fts_pkg::NUM_CTL-1:0] ctl_irq,
	output logic [63:0] id_release
);
	import fts_pkg::*;

	typedef struct packed {
		logic [SEC_W-1:0] sec;
		logic [NS_W-1:0] ns;
		logic pps;
		logic [NS_W-1:0] trim_cnt;
		logic [NS_W-1:0] trim_interval;
		logic trim_minus;
		logic trim_en;
		fts_ctl_type [NUM_CTL-1:0] ctl;
		logic [NUM_CTL-1:0] pin_s1;
		logic [NUM_CTL-1:0] pin_s2;
		logic [NUM_CTL-1:0] pin_d;
		logic [NUM_CTL-1:0] irq;
		logic [NUM_CTL-1:0] mask;
		logic [63:0] id_rel;
		logic [Q_PTR_W-1:0] wr_ptr;
		logic [Q_PTR_W-1:0] rd_ptr;
		logic ovfl;
		logic [31:0] prdata;
	} fts_main_state_type;

	fts_main_state_type s;
	fts_main_state_type next_s;
	logic [ENTRY_W-1:0] q_mem [Q_DEPTH];
	logic [ENTRY_W-1:0] head;
	logic [NUM_PORTS-1:0] enq_vld;
	logic [NUM_PORTS-1:0][ENTRY_W-1:0] enq_entry;
	logic [ENTRY_W-1:0] enq_pick;
	logic q_wr;
	logic [NS_W-1:0] step;
	logic [NS_W:0] wall_sum;
	logic [NS_W:0] delta_sum;
	logic wrapped;
	logic [NUM_CTL-1:0] edge_det;
	logic load_hit;
	logic delta_hit;
	logic [SEC_W-1:0] load_sec;
	logic [NS_W-1:0] load_ns;
	logic [NS_W-1:0] delta_ns;
	logic [CTL_IDX_W:0] wr_dec;
	logic [32:0] rd_res;
	logic apb_wr;

	fts_wall_if wall ();
	assign wall.sec = s.sec;
	assign wall.ns = s.ns;

	// Returns {hit, index} for the per-controller register window
	function automatic logic [CTL_IDX_W:0] ctl_decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] diff;
		diff = a - CTL_BASE;
		return {(a >= CTL_BASE) && (a < CTL_END), diff[CTL_IDX_W+4:5]};
	endfunction : ctl_decode

	// Returns {hit, data}; unaligned or unmapped addresses miss
	function automatic logic [32:0] reg_read(input fts_main_state_type st,
			input logic [ENTRY_W-1:0] hd, input logic [ADDR_W-1:0] a);
		logic [31:0] d;
		logic hit;
		logic [CTL_IDX_W:0] dec;
		fts_ctl_type c;
		d = '0;
		hit = (a[1:0] == 2'h0);
		dec = ctl_decode(a);
		c = st.ctl[dec[CTL_IDX_W-1:0]];
		if (dec[CTL_IDX_W]) begin
			case (a[4:0])
				CTL_CTRL: d = {27'h0, c.arm, c.invert, c.sync, c.action};
				CTL_SEC_LO: d = c.sec[31:0];
				CTL_SEC_HI: d = {16'h0, c.sec[SEC_W-1:32]};
				CTL_NS: d = {2'h0, c.ns};
				CTL_WAVE_HIGH: d = {2'h0, c.wave_high};
				CTL_WAVE_LOW: d = {2'h0, c.wave_low};
				default: hit = 1'b0;
			endcase
		end else begin
			case (a)
				REG_WALL_SEC_LO: d = st.sec[31:0];
				REG_WALL_SEC_HI: d = {16'h0, st.sec[SEC_W-1:32]};
				REG_WALL_NS: d = {2'h0, st.ns};
				REG_RATE_TRIM: d = {st.trim_en, st.trim_minus, st.trim_interval};
				REG_ID_RELEASE_LOWER, REG_ID_RELEASE_UPPER, REG_QUEUE_ADVANCE: d = '0;
				REG_STAMP_QUEUE_STATUS: begin
					d[ST_VLD] = (st.wr_ptr != st.rd_ptr);
					d[ST_ID_LSB +: ID_W] = hd[ENT_ID_LSB +: ID_W];
					d[ST_PORT_LSB +: PORT_W] = hd[ENT_PORT_LSB +: PORT_W];
					d[ST_OVFL] = st.ovfl;
					d[ST_STAMP_HI_LSB +: 16] = hd[STAMP_W-1:32];
				end
				REG_TX_STAMP_VALUE: d = hd[31:0];
				REG_IRQ_MASK: d = {28'h0, st.mask};
				default: hit = 1'b0;
			endcase
		end
		return {hit, d};
	endfunction : reg_read

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		fts_port_stamper #(
			.PORT_NUM(PORT_W'(p))
		) u_port (
			.ref_clk(ref_clk),
			.rst(rst),
			.ce(ce),
			.wall(wall.snk),
			.rx_sof(rx_sof[p]),
			.rx_redirect_req(rx_redirect_req[p]),
			.rx_copy_req(rx_copy_req[p]),
			.rx_stamp_vld(rx_stamp_vld[p]),
			.rx_stamp(rx_stamp[p]),
			.rx_redirect(rx_redirect[p]),
			.rx_copy(rx_copy[p]),
			.rx_forward(rx_forward[p]),
			.tx_sof(tx_sof[p]),
			.tx_op(tx_op[p]),
			.tx_rx_stamp(tx_rx_stamp[p]),
			.tx_id(tx_id[p]),
			.corr_vld(corr_vld[p]),
			.corr_residence(corr_residence[p]),
			.origin_vld(origin_vld[p]),
			.origin_time(origin_time[p]),
			.enq_vld(enq_vld[p]),
			.enq_entry(enq_entry[p])
		);
	end

	assign head = q_mem[s.rd_ptr[Q_IDX_W-1:0]];
	assign apb_wr = psel & penable & pwrite;
	assign wr_dec = ctl_decode(paddr);
	assign rd_res = reg_read(s, head, paddr);

	always_comb begin
		next_s = s;
		next_s.id_rel = '0;
		next_s.irq = '0;
		next_s.pps = 1'b0;
		next_s.pin_s1 = sync_pin_in;
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_d = s.pin_s2;
		step = NS_STEP;
		if (s.trim_en) begin
			if (s.trim_cnt >= s.trim_interval) begin
				next_s.trim_cnt = '0;
				step = s.trim_minus ? NS_STEP - NS_ONE : NS_STEP + NS_ONE;
			end else begin
				next_s.trim_cnt = s.trim_cnt + NS_ONE;
			end
		end
		wall_sum = ns_add(s.ns, step);
		wrapped = wall_sum[NS_W];
		next_s.ns = wall_sum[NS_W-1:0];
		if (wrapped) begin
			next_s.sec = s.sec + 48'h1;
			next_s.pps = 1'b1;
		end
		edge_det = (s.pin_s2 ^ s.pin_d) & s.pin_s2;
		load_hit = 1'b0;
		delta_hit = 1'b0;
		load_sec = '0;
		load_ns = '0;
		delta_ns = '0;
		// Descending walk gives the lowest controller priority among loads or among deltas; any load beats any delta on the wall time
		// four identical controllers
		for (int k = NUM_CTL - 1; k >= 0; k--) begin
			edge_det[k] = (s.pin_s2[k] ^ s.pin_d[k]) & (s.pin_s2[k] ^ s.ctl[k].invert);
			if (s.ctl[k].arm && s.ctl[k].action != ACT_CLOCK
					&& (!s.ctl[k].sync || edge_det[k])) begin
				next_s.ctl[k].arm = 1'b0;
				next_s.irq[k] = 1'b1;
				case (s.ctl[k].action)
					ACT_LOAD: begin
						load_hit = 1'b1;
						load_sec = s.ctl[k].sec;
						load_ns = s.ctl[k].ns;
					end
					ACT_DELTA: begin
						delta_hit = 1'b1;
						delta_ns = s.ctl[k].ns;
					end
					ACT_STORE: begin
						next_s.ctl[k].sec = s.sec;
						next_s.ctl[k].ns = s.ns;
					end
					default: begin
					end
				endcase
			end
			// Compare time including this cycle so each phase lasts its setting exactly
			next_s.ctl[k].elapsed = s.ctl[k].elapsed + step;
			case (s.ctl[k].wave)
				WV_IDLE: begin
					next_s.ctl[k].elapsed = '0;
					if (s.ctl[k].arm && s.ctl[k].action == ACT_CLOCK) begin
						if (!s.ctl[k].sync) begin
							next_s.ctl[k].wave = WV_ACTIVE;
							next_s.irq[k] = 1'b1;
						end else if (wrapped) begin
							next_s.ctl[k].wave = WV_WAIT;
						end
					end
				end
				WV_WAIT: begin
					if (next_s.ctl[k].elapsed >= s.ctl[k].wave_low) begin
						next_s.ctl[k].wave = WV_ACTIVE;
						next_s.ctl[k].elapsed = '0;
						next_s.irq[k] = 1'b1;
					end
				end
				WV_ACTIVE: begin
					if (next_s.ctl[k].elapsed >= s.ctl[k].wave_high) begin
						next_s.ctl[k].elapsed = '0;
						if (s.ctl[k].sync) begin
							next_s.ctl[k].wave = WV_IDLE;
							next_s.ctl[k].arm = 1'b0;
						end else begin
							next_s.ctl[k].wave = WV_INACT;
						end
					end
				end
				WV_INACT: begin
					if (next_s.ctl[k].elapsed >= s.ctl[k].wave_low) begin
						next_s.ctl[k].wave = WV_ACTIVE;
						next_s.ctl[k].elapsed = '0;
						next_s.irq[k] = 1'b1;
					end
				end
				default: next_s.ctl[k].wave = WV_IDLE;
			endcase
			// Disarming or changing action stops the waveform at once
			if (!s.ctl[k].arm || s.ctl[k].action != ACT_CLOCK) begin
				next_s.ctl[k].wave = WV_IDLE;
			end
			next_s.ctl[k].pin_out = (next_s.ctl[k].wave == WV_ACTIVE) ^ s.ctl[k].invert;
			next_s.ctl[k].pin_oe = (s.ctl[k].action == ACT_CLOCK);
		end
		delta_sum = '0;
		if (load_hit) begin
			next_s.sec = load_sec;
			next_s.ns = load_ns;
		end else if (delta_hit) begin
			delta_sum = ns_add(next_s.ns, delta_ns);
			next_s.ns = delta_sum[NS_W-1:0];
			if (delta_sum[NS_W]) begin
				next_s.sec = next_s.sec + 48'h1;
			end
		end else begin
			delta_sum = '0;
		end
		if (psel && !penable) begin
			next_s.prdata = rd_res[31:0];
		end
		// Software writes come after hardware so a written arm bit is never lost
		if (apb_wr && paddr[1:0] == 2'h0) begin
			if (wr_dec[CTL_IDX_W]) begin
				case (paddr[4:0])
					CTL_CTRL: begin
						next_s.ctl[wr_dec[CTL_IDX_W-1:0]].action =
							fts_action_type'(pwdata[CTRL_ACT_LSB +: 2]);
						next_s.ctl[wr_dec[CTL_IDX_W-1:0]].sync = pwdata[CTRL_SYNC];
						next_s.ctl[wr_dec[CTL_IDX_W-1:0]].invert = pwdata[CTRL_INV];
						next_s.ctl[wr_dec[CTL_IDX_W-1:0]].arm = pwdata[CTRL_ARM];
					end
					CTL_SEC_LO: next_s.ctl[wr_dec[CTL_IDX_W-1:0]].sec[31:0] = pwdata;
					CTL_SEC_HI: next_s.ctl[wr_dec[CTL_IDX_W-1:0]].sec[SEC_W-1:32] = pwdata[15:0];
					CTL_NS: next_s.ctl[wr_dec[CTL_IDX_W-1:0]].ns = pwdata[NS_W-1:0];
					CTL_WAVE_HIGH: next_s.ctl[wr_dec[CTL_IDX_W-1:0]].wave_high = pwdata[NS_W-1:0];
					CTL_WAVE_LOW: next_s.ctl[wr_dec[CTL_IDX_W-1:0]].wave_low = pwdata[NS_W-1:0];
					default: begin
					end
				endcase
			end else begin
				case (paddr)
					REG_RATE_TRIM: begin
						next_s.trim_interval = pwdata[NS_W-1:0];
						next_s.trim_minus = pwdata[TRIM_MINUS];
						next_s.trim_en = pwdata[TRIM_EN];
						next_s.trim_cnt = '0;
					end
					REG_ID_RELEASE_LOWER: next_s.id_rel[31:0] = pwdata;
					REG_ID_RELEASE_UPPER: next_s.id_rel[63:32] = pwdata;
					REG_QUEUE_ADVANCE: begin
						if (s.wr_ptr != s.rd_ptr) begin
							next_s.rd_ptr = s.rd_ptr + 1'b1;
						end
					end
					REG_IRQ_MASK: next_s.mask = pwdata[NUM_CTL-1:0];
					default: begin
					end
				endcase
			end
		end
		if (psel && penable && !pwrite && paddr == REG_STAMP_QUEUE_STATUS) begin
			next_s.ovfl = 1'b0;
		end
		q_wr = 1'b0;
		enq_pick = '0;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			if (enq_vld[p]) begin
				enq_pick = enq_entry[p];
			end
		end
		if (|enq_vld) begin
			if ((s.wr_ptr - s.rd_ptr) == Q_PTR_W'(Q_DEPTH)) begin
				next_s.ovfl = 1'b1;
			end else begin
				q_wr = 1'b1;
				next_s.wr_ptr = s.wr_ptr + 1'b1;
			end
			// One write port: simultaneous stamps beyond the first are lost
			if ((enq_vld & (enq_vld - 1'b1)) != '0) begin
				next_s.ovfl = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Storage has no reset; the pointers alone say what is valid
	always_ff @(posedge ref_clk) begin
		if (ce && q_wr) begin
			q_mem[s.wr_ptr[Q_IDX_W-1:0]] <= enq_pick;
		end
	end

	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~rd_res[32];
	assign pps = s.pps;
	assign ctl_irq = s.irq & s.mask;
	assign id_release = s.id_rel;
	for (genvar k = 0; k < NUM_CTL; k++) begin : g_pin
		assign sync_pin_out[k] = s.ctl[k].pin_out;
		assign sync_pin_oe[k] = s.ctl[k].pin_oe;
	end
endmodule : fts_time_stamp_top

// File: testbench/fts_time_stamp_sva.sv
`timescale 1ns/1ns
module fts_time_stamp_sva #(
	parameter int NUM_PORTS = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fts_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [NUM_PORTS-1:0] rx_sof,
	input wire logic [NUM_PORTS-1:0] rx_stamp_vld,
	input wire logic [NUM_PORTS-1:0][fts_pkg::STAMP_W-1:0] rx_stamp,
	input wire logic [NUM_PORTS-1:0] tx_sof,
	input wire logic [NUM_PORTS-1:0][2:0] tx_op,
	input wire logic [NUM_PORTS-1:0] corr_vld,
	input wire logic [NUM_PORTS-1:0] origin_vld,
	input wire logic [63:0] id_release
);
	import fts_pkg::*;
	logic wr;
	assign wr = psel && penable && pwrite && ce;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	AST_RX_VLD: assert property (rx_sof[0] && ce |=> rx_stamp_vld[0])
		else $error("rx valid missing");
	AST_RX_ONLY: assert property (!(rx_sof[0] && ce) |=> !rx_stamp_vld[0])
		else $error("rx valid unasked");
	AST_SHARED: assert property (&rx_sof[1:0] && ce |=> rx_stamp[0] == rx_stamp[1])
		else $error("port stamps differ");
	AST_ONE_STEP: assert property (tx_sof[1] && ce |=>
		corr_vld[1] == ($past(tx_op[1]) == OP_ONE_STEP)) else $error("corr valid wrong");
	AST_NO_CORR: assert property (!(tx_sof[1] && ce) |=> !corr_vld[1])
		else $error("corr valid unasked");
	AST_ORIGIN: assert property (tx_sof[1] && ce |=>
		origin_vld[1] == ($past(tx_op[1]) == OP_ORIGIN)) else $error("origin valid wrong");
	AST_ID_LO: assert property (wr && paddr == REG_ID_RELEASE_LOWER |=>
		id_release[31:0] == $past(pwdata) ##1 id_release == 64'h0) else $error("id low");
	AST_ID_HI: assert property (wr && paddr == REG_ID_RELEASE_UPPER |=>
		id_release == {$past(pwdata), 32'h0}) else $error("id high");
endmodule : fts_time_stamp_sva
bind fts_time_stamp_top fts_time_stamp_sva #(.NUM_PORTS(NUM_PORTS)) fts_time_stamp_sva_inst (
	.ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .rx_sof, .rx_stamp_vld,
	.rx_stamp, .tx_sof, .tx_op, .corr_vld, .origin_vld, .id_release);

// File: testbench/fts_timing_equip.sv
`timescale 1ns/1ns
module fts_timing_equip (
	input wire logic ref_clk,
	input wire logic [3:0] edge_req,
	input wire logic [3:0] sync_pin_out,
	input wire logic [3:0] sync_pin_oe,
	output logic [3:0] sync_pin_in
);
	logic [3:0] level = 4'h0;
	always @(posedge ref_clk) level <= level ^ edge_req;
	// Device owns pin only when enabled
	assign sync_pin_in = (sync_pin_oe & sync_pin_out) | (~sync_pin_oe & level);
endmodule : fts_timing_equip

// File: testbench/frame_time_stamp_and_tod_tb.sv
`timescale 1ns/1ns
module frame_time_stamp_and_tod_tb;
	import fts_pkg::*;
	logic ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr, pps, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] rx_sof, rx_redirect_req, rx_copy_req, rx_stamp_vld, rx_redirect, rx_copy;
	logic [3:0] rx_forward, tx_sof, corr_vld, origin_vld, sync_pin_in, sync_pin_out;
	logic [3:0] sync_pin_oe, ctl_irq, edge_req;
	logic [3:0][STAMP_W-1:0] rx_stamp, tx_rx_stamp;
	logic [3:0][2:0] tx_op;
	logic [3:0][ID_W-1:0] tx_id;
	logic [3:0][NS_W-1:0] corr_residence;
	logic [3:0][ORIGIN_W-1:0] origin_time;
	logic [63:0] id_release;
	logic [47:0] s;
	int miscompares, compares, cyc, n;
	fts_time_stamp_top fts_time_stamp_top_inst (.ref_clk, .rst, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_sof, .rx_redirect_req, .rx_copy_req,
		.rx_stamp_vld, .rx_stamp, .rx_redirect, .rx_copy, .rx_forward, .tx_sof, .tx_op,
		.tx_rx_stamp, .tx_id, .corr_vld, .corr_residence, .origin_vld, .origin_time,
		.sync_pin_in, .sync_pin_out, .sync_pin_oe, .pps, .ctl_irq, .id_release);
	fts_timing_equip fts_timing_equip_inst (.ref_clk, .edge_req, .sync_pin_out, .sync_pin_oe,
		.sync_pin_in);
	task automatic give_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string name, input logic [47:0] e, input logic [47:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic wirq(input int k, input logic e);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ctl_irq[k] !== 1'b1 && n < 12);
		chk("irq", e, ctl_irq[k]);
	endtask : wirq
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx_sof, rx_redirect_req, rx_copy_req} = '0;
		{tx_sof, tx_op, tx_rx_stamp, tx_id, edge_req} = '0;
		ce = 1'b1;
		rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rx_redirect_req <= 4'h2;
		rx_copy_req <= 4'h3;
		rx_sof <= 4'h3;
		@(posedge ref_clk);
		rx_sof <= 4'h0;
		tx_id[1] <= 6'h2A;
		@(negedge ref_clk);
		chk("rx", 8'hE5, {rx_stamp_vld[1:0], rx_redirect[1:0], rx_copy[1:0], rx_forward[1:0]});
		chk("shared", rx_stamp[0], rx_stamp[1]);
		chk("stamp", 0, rx_stamp[0]);
		for (int o = 0; o < 8; o++) begin
			@(posedge ref_clk);
			rx_sof <= 4'h1;
			@(posedge ref_clk);
			rx_sof <= 4'h0;
			repeat (3) @(posedge ref_clk);
			tx_rx_stamp[1] <= rx_stamp[0];
			tx_op[1] <= 3'(o);
			tx_sof[1] <= 1'b1;
			@(posedge ref_clk);
			tx_sof[1] <= 1'b0;
			@(negedge ref_clk);
			chk("op", {o == 2, o == 5}, {corr_vld[1], origin_vld[1]});
			if (o == 5) chk("origin", tx_rx_stamp[1] + 80, origin_time[1][47:0]);
			if (o == 2) chk("residence", 80, corr_residence[1]);
		end
		$display("test stamping done");
		@(posedge ref_clk);
		for (int m = 0; m < 3; m++) begin
			apb(1, REG_RATE_TRIM, m == 2 ? 32'h0 : {1'b1, m[0], 30'h0});
			apb(0, REG_WALL_NS, 32'h0);
			s = rd;
			apb(0, REG_WALL_NS, 32'h0);
			chk("trim", s + (m == 2 ? 60 : m == 0 ? 63 : 57), rd);
		end
		// Clock enable low must freeze the wall time
		apb(0, REG_WALL_NS, 32'h0);
		s = rd;
		ce <= 1'b0;
		repeat (5) @(posedge ref_clk);
		ce <= 1'b1;
		apb(0, REG_WALL_NS, 32'h0);
		chk("freeze", s + 60, rd);
		apb(0, REG_STAMP_QUEUE_STATUS, 32'h0);
		chk("head", {1'b0, 4'h1, 6'h2A, 1'b1}, rd[11:0]);
		apb(1, REG_QUEUE_ADVANCE, 32'h0);
		apb(0, REG_STAMP_QUEUE_STATUS, 32'h0);
		chk("empty", 0, rd[0]);
		tx_op[2] <= 3'h3;
		tx_sof[2] <= 1'b1;
		repeat (129) @(posedge ref_clk);
		tx_sof[2] <= 1'b0;
		// The last dropped stamp lands one edge later
		@(posedge ref_clk);
		apb(0, REG_STAMP_QUEUE_STATUS, 32'h0);
		chk("overflow", {1'b1, 4'h2, 6'h0, 1'b1}, rd[11:0]);
		apb(1, REG_ID_RELEASE_LOWER, 32'h8000_0001);
		apb(1, REG_ID_RELEASE_UPPER, 32'h0000_0004);
		apb(0, 12'h0FC, 32'h0);
		chk("unmapped", 1, err);
		$display("test registers done");
		apb(1, REG_IRQ_MASK, 32'h0000_000B);
		apb(1, 12'h064, 32'h0000_0005);
		apb(1, 12'h060, 32'h0000_0010);
		wirq(1, 1);
		apb(0, REG_WALL_SEC_LO, 32'h0);
		chk("load", 5, rd);
		apb(1, 12'h080, 32'h0000_0012);
		wirq(2, 0);
		apb(0, 12'h084, 32'h0);
		chk("store", 5, rd);
		apb(1, 12'h06C, 32'(NS_PER_SEC) - 32'h0000_0028);
		apb(0, REG_WALL_NS, 32'h0);
		s = rd;
		apb(1, 12'h060, 32'h0000_0011);
		apb(0, REG_WALL_NS, 32'h0);
		chk("delta", s + 80, rd);
		apb(0, REG_WALL_SEC_LO, 32'h0);
		chk("carry", 6, rd);
		apb(1, 12'h06C, 32'(NS_PER_SEC) - 32'h0000_003C);
		apb(1, 12'h060, 32'h0000_0010);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pps !== 1'b1 && n < 12);
		chk("pps", 4, n);
		apb(0, REG_WALL_SEC_LO, 32'h0);
		chk("wrap", 6, rd);
		apb(1, 12'h0A0, 32'h0000_001E);
		for (int i = 0; i < 3; i++) begin
			wirq(3, i == 2);
			edge_req <= 4'h8;
			@(posedge ref_clk);
			edge_req <= 4'h0;
		end
		apb(1, 12'h050, 32'h0000_003C);
		apb(1, 12'h054, 32'h0000_0028);
		apb(1, 12'h040, 32'h0000_0013);
		wirq(0, 1);
		wirq(0, 1);
		chk("period", (60 + 40) / CLK_PERIOD_NS, n);
		chk("pin level", 1, sync_pin_out[0]);
		chk("pin drive", 1, sync_pin_oe[0]);
		$display("test controllers done");
		give_verdict();
	end
endmodule : frame_time_stamp_and_tod_tb
